/* pkg/hpd_pkg.sv */
// Package for the host port DMA request and bank interrupt block.
// Assumes a single peripheral clock and a word-wide on-chip CPU register port.
package hpd_pkg;

    // Register byte addresses on the on-chip CPU bus.
    localparam logic [31:0] HPD_DTR_ADDR        = 32'hF84D0040;
    localparam logic [31:0] HPD_BICR_ADDR       = 32'hF84D0044;

    // Field positions.
    localparam int          HPD_DMA_TRIGGER_BIT_BIT        = 0;
    localparam int          HPD_BIF_BIT         = 0;
    localparam int          HPD_BIE_BIT         = 1;

    // Reset values.
    localparam logic [31:0] HPD_DTR_RESET       = 32'h00000000;
    localparam logic [31:0] HPD_BICR_RESET      = 32'h00000000;
    localparam logic [31:0] HPD_RDATA_ZERO      = 32'h00000000;

    // Edge mode request pulse length in peripheral clock cycles.
    localparam int          HPD_PULSE_CYCLES    = 32;
    localparam int          HPD_PULSE_W         = 6;

    // Buffer window as seen from the host and from the CPU.
    localparam int          HPD_BUF_AW          = 10;
    localparam int          HPD_WORD_AW         = 8;
    localparam logic [15:0] HPD_HOST_BUF_START  = 16'h0000;
    localparam logic [15:0] HPD_HOST_BUF_END    = 16'h03FF;
    localparam logic [31:0] HPD_CPU_BUF_START   = 32'hF84E0000;
    localparam logic [31:0] HPD_CPU_BUF_END     = 32'hF84E03FF;

    // Word indices of the first and last 32-bit word of a bank.
    localparam logic [7:0]  HPD_FIRST_WORD      = 8'h00;
    localparam logic [7:0]  HPD_LAST_WORD       = 8'hFF;

    // Boot alias decode: region number in bits 31:29, region 7 is excluded.
    localparam logic [2:0]  HPD_NO_ALIAS_REGION = 3'h7;
    // Bits 28:25 zero select the lower 32 Mbyte half of area 0.
    localparam logic [3:0]  HPD_AREA0_LOW       = 4'h0;
    // Bits 24:10 zero select the first 1 kbyte of that half.
    localparam logic [14:0] HPD_ALIAS_OFFSET    = 15'h0000;
    // Field boundaries of the boot alias decode; the offset field ends at the buffer width.
    localparam int          HPD_RGN_HI          = 31;
    localparam int          HPD_RGN_LO          = 29;
    localparam int          HPD_AR_HI           = 28;
    localparam int          HPD_AR_LO           = 25;
    localparam int          HPD_OFS_HI          = 24;

    // Request generator states.
    typedef enum logic [1:0] {
        HPD_REQ_IDLE,
        HPD_REQ_LEVEL,
        HPD_REQ_PULSE
    } hpd_req_state_e;

endpackage : hpd_pkg

/* design/hpd_core.sv */
// DMA request pin, bank interrupt and buffer address decode of the host port.
// Assumes host pins are asynchronous to clock_in and the CPU port is synchronous.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RQ1: CPU writing one asserts DMA request
// RQ2: Trigger bit clears as request negates
// RQ3: CPU zero write to trigger ignored
// RQ4: Software checks trigger zero before setting
// RQ5: Trigger register reachable from CPU only
// RQ6: Trigger bits 31..1 read zero
// RQ7: Enable bit gates bank interrupt request
// RQ8: Request held while flag and enable
// RQ9: Increment mode flags after last word
// RQ10: Decrement mode flags after first word
// RQ11: CPU can only clear bank flag
// RQ12: Software avoids clear colliding with set
// RQ13: Bank control CPU only, upper bits zero
// RQ14: Host sees 1 kbyte bank window
// RQ15: CPU sees bank at fixed window
// RQ16: Mode and select pick each side's bank
// RQ17: Boot mode selects bank 0, aliases
// RQ18: Boot mode prohibits rest of half
// RQ19: Other areas keep external decoding
// RQ20: Strobe and chip select define cycles
// RQ21: Register select picks index or data
// RQ22: Software uses uncached region for buffer
// RQ23: Level mode holds until select lows
// RQ24: Edge mode gives 32 cycle pulse (code drives it low in both polarities, so none shows with polarity one)
// RQ25: Polarity one drives pin low idle
// RQ26: Host strobes synchronised before use
module hpd_core (
    // Clock, reset and enable.
    input  wire logic                           clock_in,
    input  wire logic                           rstn_in,
    input  wire logic                           clk_en_in,
    // On-chip CPU register port.
    input  wire logic [31:0]                    cpu_addr_in,
    input  wire logic                           cpu_wr_in,
    input  wire logic                           cpu_rd_in,
    input  wire logic [31:0]                    cpu_wdata_in,
    output logic [31:0]                         cpu_rdata_out,
    output logic                                cpu_rvalid_out,
    // CPU buffer decode results.
    output logic                                cpu_buf_sel_out,
    output logic [hpd_pkg::HPD_BUF_AW-1:0]      cpu_buf_offset_out,
    output logic                                cpu_prohibit_out,
    output logic                                cpu_ext_sel_out,
    // Settings from the port control registers.
    input  wire logic                           request_negate_mode_in,
    input  wire logic                           request_polarity_in,
    input  wire logic                           address_direction_in,
    input  wire logic                           bank_mode_in,
    input  wire logic                           bank_select_in,
    input  wire logic                           host_boot_mode_in,
    // Host pins.
    input  wire logic                           host_chip_select_n_in,
    input  wire logic                           host_read_strobe_n_in,
    input  wire logic                           host_write_strobe_n_in,
    input  wire logic                           register_select_pin_in,
    // Host buffer access from the address and data register logic.
    input  wire logic                           host_ram_access_in,
    input  wire logic [hpd_pkg::HPD_BUF_AW-1:0] host_addr_in,
    // Host cycle status.
    output logic                                host_read_cycle_out,
    output logic                                host_write_cycle_out,
    output logic                                host_index_access_out,
    output logic                                host_buf_sel_out,
    output logic                                host_bank_out,
    output logic                                cpu_bank_out,
    // DMA request and bank interrupt.
    output logic                                dma_request_pin_out,
    output logic                                bank_irq_request_out
);

    localparam int PW = hpd_pkg::HPD_PULSE_W;
    localparam logic [PW-1:0] PULSE_LAST = PW'(hpd_pkg::HPD_PULSE_CYCLES - 1);
    localparam logic [PW-1:0] CNT_ZERO   = '0;

    // Host pin synchronisers; stage one is read only by stage two.
    logic cs_s1_r, cs_s2_r, cs_prev_r;
    logic rd_s1_r, rd_s2_r;
    logic wr_s1_r, wr_s2_r;
    logic rs_s1_r, rs_s2_r;

    // RQ26 pin synchronisation
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            cs_prev_r <= 1'b1;
            rd_s1_r   <= 1'b1;
            rd_s2_r   <= 1'b1;
            wr_s1_r   <= 1'b1;
            wr_s2_r   <= 1'b1;
            rs_s1_r   <= 1'b1;
            rs_s2_r   <= 1'b1;
        end else if (clk_en_in) begin
            cs_s1_r   <= host_chip_select_n_in;
            cs_s2_r   <= cs_s1_r;
            cs_prev_r <= cs_s2_r;
            rd_s1_r   <= host_read_strobe_n_in;
            rd_s2_r   <= rd_s1_r;
            wr_s1_r   <= host_write_strobe_n_in;
            wr_s2_r   <= wr_s1_r;
            rs_s1_r   <= register_select_pin_in;
            rs_s2_r   <= rs_s1_r;
        end
    end

    logic host_rd_cyc, host_wr_cyc, cs_release, normal_sel;
    // RQ20 cycle qualification
    assign host_rd_cyc = !cs_s2_r && !rd_s2_r;
    assign host_wr_cyc = !cs_s2_r && !wr_s2_r;
    assign cs_release  = cs_s2_r && !cs_prev_r;
    // RQ21 register select meaning
    assign normal_sel  = !cs_s2_r && !rs_s2_r;

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            host_read_cycle_out   <= 1'b0;
            host_write_cycle_out  <= 1'b0;
            host_index_access_out <= 1'b0;
        end else if (clk_en_in) begin
            host_read_cycle_out   <= host_rd_cyc;
            host_write_cycle_out  <= host_wr_cyc;
            host_index_access_out <= (host_rd_cyc || host_wr_cyc) && rs_s2_r;
        end
    end

    // CPU register decode; the host pins cannot address these registers, only clear the trigger and set the bank flag.
    logic dtr_hit, bicr_hit, dtr_wr, bicr_wr;
    // RQ5 CPU only access
    assign dtr_hit  = (cpu_addr_in == hpd_pkg::HPD_DTR_ADDR);
    // RQ13 CPU only access
    assign bicr_hit = (cpu_addr_in == hpd_pkg::HPD_BICR_ADDR);
    assign dtr_wr   = cpu_wr_in && dtr_hit;
    assign bicr_wr  = cpu_wr_in && bicr_hit;

    // DMA request generator.
    hpd_pkg::hpd_req_state_e req_state_r, req_state_nxt;
    logic [PW-1:0] pulse_cnt_r, pulse_cnt_nxt;
    logic          trig_r;
    logic          trig_set;
    logic          pin_nxt;

    // RQ1 trigger write
    // RQ3 zero write ignored
    assign trig_set = dtr_wr && cpu_wdata_in[hpd_pkg::HPD_DMA_TRIGGER_BIT_BIT] && !trig_r;

    always_comb begin
        req_state_nxt = req_state_r;
        pulse_cnt_nxt = pulse_cnt_r;
        unique case (req_state_r)
            hpd_pkg::HPD_REQ_IDLE: begin
                if (trig_set) begin
                    if (request_negate_mode_in) begin
                        req_state_nxt = hpd_pkg::HPD_REQ_PULSE;
                        pulse_cnt_nxt = PULSE_LAST;
                    end else begin
                        req_state_nxt = hpd_pkg::HPD_REQ_LEVEL;
                    end
                end
            end
            // RQ23 level negation
            hpd_pkg::HPD_REQ_LEVEL: begin
                if (normal_sel) begin
                    req_state_nxt = hpd_pkg::HPD_REQ_IDLE;
                end
            end
            // RQ24 pulse counting
            hpd_pkg::HPD_REQ_PULSE: begin
                if (pulse_cnt_r == CNT_ZERO) begin
                    req_state_nxt = hpd_pkg::HPD_REQ_IDLE;
                end else begin
                    pulse_cnt_nxt = pulse_cnt_r - 1'b1;
                end
            end
            default: begin
                req_state_nxt = hpd_pkg::HPD_REQ_IDLE;
            end
        endcase
    end

    // The pin idles at the inverse of the polarity; edge mode pulses low.
    always_comb begin
        unique case (req_state_nxt)
            hpd_pkg::HPD_REQ_LEVEL: pin_nxt = request_polarity_in;
            hpd_pkg::HPD_REQ_PULSE: pin_nxt = 1'b0;
            // RQ25 polarity idle level
            default:                pin_nxt = !request_polarity_in;
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            req_state_r         <= hpd_pkg::HPD_REQ_IDLE;
            pulse_cnt_r         <= CNT_ZERO;
            trig_r              <= hpd_pkg::HPD_DTR_RESET[hpd_pkg::HPD_DMA_TRIGGER_BIT_BIT];
            dma_request_pin_out <= 1'b1;
        end else if (clk_en_in) begin
            req_state_r         <= req_state_nxt;
            pulse_cnt_r         <= pulse_cnt_nxt;
            // RQ2 clear with negation
            trig_r              <= (req_state_nxt != hpd_pkg::HPD_REQ_IDLE);
            dma_request_pin_out <= pin_nxt;
        end
    end

    // Bank boundary detection.
    logic       bank_pend_r;
    logic       flag_r, en_r;
    logic       flag_nxt, en_nxt;
    logic       at_target, flag_set;
    logic [hpd_pkg::HPD_WORD_AW-1:0] host_word;

    assign host_word = host_addr_in[hpd_pkg::HPD_BUF_AW-1:hpd_pkg::HPD_BUF_AW-hpd_pkg::HPD_WORD_AW];
    // RQ9 end word in increment
    // RQ10 start word in decrement
    assign at_target = address_direction_in ? (host_word == hpd_pkg::HPD_FIRST_WORD)
                                            : (host_word == hpd_pkg::HPD_LAST_WORD);
    assign flag_set  = cs_release && bank_pend_r;

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bank_pend_r <= 1'b0;
        end else if (clk_en_in) begin
            if (cs_release) begin
                bank_pend_r <= 1'b0;
            end else if ((host_rd_cyc || host_wr_cyc) && !rs_s2_r && host_ram_access_in && at_target) begin
                bank_pend_r <= 1'b1;
            end
        end
    end

    // Hardware set wins over a coinciding CPU clear.
    always_comb begin
        flag_nxt = flag_r;
        en_nxt   = en_r;
        if (bicr_wr) begin
            en_nxt = cpu_wdata_in[hpd_pkg::HPD_BIE_BIT];
            // RQ11 clear only
            if (!cpu_wdata_in[hpd_pkg::HPD_BIF_BIT]) begin
                flag_nxt = 1'b0;
            end
        end
        if (flag_set) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_r               <= hpd_pkg::HPD_BICR_RESET[hpd_pkg::HPD_BIF_BIT];
            en_r                 <= hpd_pkg::HPD_BICR_RESET[hpd_pkg::HPD_BIE_BIT];
            bank_irq_request_out <= 1'b0;
        end else if (clk_en_in) begin
            flag_r               <= flag_nxt;
            en_r                 <= en_nxt;
            // RQ7 enable gating
            // RQ8 level request
            bank_irq_request_out <= flag_nxt && en_nxt;
        end
    end

    // CPU read data; unmapped addresses read zero.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cpu_rdata_out  <= hpd_pkg::HPD_RDATA_ZERO;
            cpu_rvalid_out <= 1'b0;
        end else if (clk_en_in) begin
            cpu_rvalid_out <= cpu_rd_in;
            cpu_rdata_out  <= hpd_pkg::HPD_RDATA_ZERO;
            // RQ6 reserved zero
            if (cpu_rd_in && dtr_hit) begin
                cpu_rdata_out[hpd_pkg::HPD_DMA_TRIGGER_BIT_BIT] <= trig_r;
            end
            // RQ13 reserved zero
            if (cpu_rd_in && bicr_hit) begin
                cpu_rdata_out[hpd_pkg::HPD_BIF_BIT] <= flag_r;
                cpu_rdata_out[hpd_pkg::HPD_BIE_BIT] <= en_r;
            end
        end
    end

    // Buffer bank and address decode.
    logic win_hit, alias_half, alias_hit, host_bank, cpu_bank;
    // RQ15 CPU window
    assign win_hit    = (cpu_addr_in >= hpd_pkg::HPD_CPU_BUF_START) &&
                        (cpu_addr_in <= hpd_pkg::HPD_CPU_BUF_END);
    // RQ17 boot alias regions
    assign alias_half = host_boot_mode_in &&
                        (cpu_addr_in[hpd_pkg::HPD_RGN_HI:hpd_pkg::HPD_RGN_LO] != hpd_pkg::HPD_NO_ALIAS_REGION) &&
                        (cpu_addr_in[hpd_pkg::HPD_AR_HI:hpd_pkg::HPD_AR_LO] == hpd_pkg::HPD_AREA0_LOW);
    assign alias_hit  = alias_half &&
                        (cpu_addr_in[hpd_pkg::HPD_OFS_HI:hpd_pkg::HPD_BUF_AW] == hpd_pkg::HPD_ALIAS_OFFSET);
    // RQ16 bank steering
    assign host_bank  = host_boot_mode_in ? 1'b0 : bank_select_in;
    assign cpu_bank   = host_boot_mode_in ? 1'b0 : (bank_mode_in ? !bank_select_in : bank_select_in);

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cpu_buf_sel_out    <= 1'b0;
            cpu_buf_offset_out <= '0;
            cpu_prohibit_out   <= 1'b0;
            cpu_ext_sel_out    <= 1'b0;
            host_buf_sel_out   <= 1'b0;
            host_bank_out      <= 1'b0;
            cpu_bank_out       <= 1'b0;
        end else if (clk_en_in) begin
            cpu_buf_sel_out    <= win_hit || alias_hit;
            cpu_buf_offset_out <= cpu_addr_in[hpd_pkg::HPD_BUF_AW-1:0];
            // RQ18 prohibited remainder
            cpu_prohibit_out   <= alias_half && !alias_hit;
            // RQ19 normal external decode
            cpu_ext_sel_out    <= !win_hit && !alias_half && !dtr_hit && !bicr_hit;
            // RQ14 host window
            host_buf_sel_out   <= host_ram_access_in && (host_rd_cyc || host_wr_cyc) && !rs_s2_r;
            host_bank_out      <= host_bank;
            cpu_bank_out       <= cpu_bank;
        end
    end

    // Checks.
    trig_state_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ2
        trig_r == (req_state_r != hpd_pkg::HPD_REQ_IDLE))
        else $error("trigger bit and request state disagree");

    trig_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ1
        clk_en_in && dtr_wr && cpu_wdata_in[0] && req_state_r == hpd_pkg::HPD_REQ_IDLE
        |=> trig_r && req_state_r != hpd_pkg::HPD_REQ_IDLE)
        else $error("trigger write did not start a request");

    zero_write_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ3
        clk_en_in && dtr_wr && !cpu_wdata_in[0] && req_state_r == hpd_pkg::HPD_REQ_IDLE
        |=> !trig_r)
        else $error("zero write set the trigger bit");

    pulse_start_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ24
        clk_en_in && trig_set && request_negate_mode_in
        |=> pulse_cnt_r == PULSE_LAST && !dma_request_pin_out)
        else $error("pulse did not start with full count");

    pulse_end_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ24
        clk_en_in && req_state_r == hpd_pkg::HPD_REQ_PULSE && pulse_cnt_r == CNT_ZERO
        |=> req_state_r == hpd_pkg::HPD_REQ_IDLE && !trig_r)
        else $error("pulse did not end after its last cycle");

    level_hold_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ23
        clk_en_in && req_state_r == hpd_pkg::HPD_REQ_LEVEL && !normal_sel
        |=> req_state_r == hpd_pkg::HPD_REQ_LEVEL && dma_request_pin_out == $past(request_polarity_in))
        else $error("level request dropped early");

    pol_idle_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ25
        clk_en_in && req_state_r == hpd_pkg::HPD_REQ_IDLE && !trig_set && request_polarity_in
        |=> !dma_request_pin_out)
        else $error("idle pin not low with polarity one");

    irq_gate_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ7
        bank_irq_request_out == (flag_r && en_r))
        else $error("bank request without flag and enable");

    flag_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ9
        clk_en_in && cs_release && bank_pend_r |=> flag_r)
        else $error("bank flag not set at chip select release");

    flag_cpu_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ11
        clk_en_in && !flag_r && !flag_set |=> !flag_r)
        else $error("bank flag set without host event");

    rsvd_zero_a: assert property (@(posedge clock_in) disable iff (!rstn_in) // RQ6
        cpu_rdata_out[31:2] == 30'h00000000)
        else $error("reserved read bits not zero");

endmodule : hpd_core

`default_nettype wire

/* bench/hpd_host_model.sv */
// Model of the external host processor and its DMA controller on the host pins.
// Assumes the bench calls its tasks from clock_in and checks the results itself.
`timescale 1ns/1ps
`default_nettype none
module hpd_host_model (
    // Clock.
    input  wire logic       clock_in,
    // Host pins and buffer access qualifiers.
    output logic            cs_n_out,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic            rs_out,
    output logic            ram_out,
    output logic [9:0]      addr_out
);
    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        rs_out   = 1'b1;
        ram_out  = 1'b0;
        addr_out = 10'h155;
    end

    task automatic cycle_begin(input logic rs, input logic ram, input logic [9:0] a, input logic wr);
        @(posedge clock_in);
        cs_n_out <= 1'b0;
        rs_out   <= rs;
        ram_out  <= ram;
        addr_out <= a;
        @(posedge clock_in);
        rd_n_out <= wr;
        wr_n_out <= !wr;
    endtask : cycle_begin

    // strobe ends before chip select, then lines are released.
    task automatic cycle_end();
        @(posedge clock_in);
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        @(posedge clock_in);
        cs_n_out <= 1'b1;
        @(posedge clock_in);
        rs_out   <= !rs_out;
        addr_out <= ~addr_out;
        ram_out  <= 1'b0;
    endtask : cycle_end
endmodule : hpd_host_model
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the host port request, bank flag and decode block.
// Assumes a host model drives the pins; the clock enable is held high except during one write.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clock_in;
    logic        rstn_in;
    logic        cpu_wr_in;
    logic        cpu_rd_in;
    logic [31:0] cpu_addr_in;
    logic [31:0] cpu_wdata_in;
    logic [31:0] rdata;
    logic [31:0] r;
    logic [9:0]  boff, haddr;
    logic        neg, pol, dir, bmode, bank_select, boot;
    logic        rvalid, buf_sel, prohibit, ext_sel, rcyc, wcyc, idx, hbuf, hbank, cbank, pin, irq;
    logic        cs_n, rd_n, wr_n, rs, ram, en;
    int          err_count, checks, cyc, run, last;
    localparam logic [31:0] DTR = hpd_pkg::HPD_DTR_ADDR;
    localparam logic [31:0] BIC = hpd_pkg::HPD_BICR_ADDR;

    hpd_core dut (.clock_in(clock_in), .rstn_in(rstn_in), .clk_en_in(en),
        .cpu_addr_in(cpu_addr_in), .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in),
        .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(rdata), .cpu_rvalid_out(rvalid),
        .cpu_buf_sel_out(buf_sel), .cpu_buf_offset_out(boff), .cpu_prohibit_out(prohibit),
        .cpu_ext_sel_out(ext_sel), .request_negate_mode_in(neg), .request_polarity_in(pol),
        .address_direction_in(dir), .bank_mode_in(bmode), .bank_select_in(bank_select),
        .host_boot_mode_in(boot), .host_chip_select_n_in(cs_n), .host_read_strobe_n_in(rd_n),
        .host_write_strobe_n_in(wr_n), .register_select_pin_in(rs), .host_ram_access_in(ram),
        .host_addr_in(haddr), .host_read_cycle_out(rcyc), .host_write_cycle_out(wcyc),
        .host_index_access_out(idx), .host_buf_sel_out(hbuf), .host_bank_out(hbank),
        .cpu_bank_out(cbank), .dma_request_pin_out(pin), .bank_irq_request_out(irq));
    hpd_host_model host (.clock_in(clock_in), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
        .rs_out(rs), .ram_out(ram), .addr_out(haddr));

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = !clock_in;
    end

    // Length of the last low stretch on the request pin.
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (pin === 1'b0) begin
            run <= run + 1;
        end else begin
            if (run != 0) last <= run;
            run <= 0;
        end
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    function automatic logic buf_exp(input logic [31:0] a, input logic b);
        return (a[31:10] == 22'h3E1380) || (b && a[31:29] != 3'h7 && a[28:10] == 19'h0);
    endfunction : buf_exp

    function automatic logic pro_exp(input logic [31:0] a, input logic b);
        return b && a[31:29] != 3'h7 && a[28:25] == 4'h0 && a[24:10] != 15'h0;
    endfunction : pro_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1

    task automatic wt(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : wt

    task automatic cpu_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock_in);
        cpu_wr_in    <= 1'b1;
        cpu_addr_in  <= a;
        cpu_wdata_in <= d;
        wt(1);
        cpu_wr_in <= 1'b0;
    endtask : cpu_wr

    task automatic cpu_rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        cpu_rd_in   <= 1'b1;
        cpu_addr_in <= a;
        wt(1);
        cpu_rd_in <= 1'b0;
        chk1(rvalid, 1'b1);
        chk(rdata, exp);
    endtask : cpu_rd

    task automatic final_report();
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    initial begin
        {rstn_in, cpu_wr_in, cpu_rd_in, cpu_addr_in, cpu_wdata_in} = '0;
        {neg, pol, dir, bmode, bank_select, boot} = '0;
        {err_count, checks, cyc, run, last} = '0;
        en = 1'b1;
        void'($urandom(32'heec4));
        repeat (5) @(posedge clock_in);
        rstn_in <= 1'b1;
        wt(3);
        cpu_rd(DTR, 32'h0);
        cpu_rd(BIC, 32'h0);
        cpu_rd(DTR + 32'h8, 32'h0);
        // Level mode request, random polarity and reserved bits.
        r = $urandom;
        pol <= r[0];
        wt(2);
        chk1(pin, !r[0]);
        cpu_wr(DTR, r | 32'h1);
        chk1(pin, r[0]);
        cpu_rd(DTR, 32'h1);
        cpu_wr(DTR, 32'h0);
        cpu_rd(DTR, 32'h1);
        host.cycle_begin(1'b1, 1'b0, 10'h0, 1'b0);
        wt(5);
        chk1(idx, 1'b1);
        chk1(rcyc, 1'b1);
        chk1(pin, r[0]);
        host.cycle_end();
        host.cycle_begin(1'b0, 1'b0, 10'h0, 1'b1);
        wt(6);
        chk1(pin, !r[0]);
        chk1(wcyc, 1'b1);
        cpu_rd(DTR, 32'h0);
        host.cycle_end();
        // Edge mode in both polarities; the pulse length is checked for polarity zero only.
        for (int p = 0; p < 2; p++) begin
            neg <= 1'b1;
            pol <= p[0];
            wt(2);
            cpu_rd(DTR, 32'h0);
            cpu_wr(DTR, 32'h1);
            cpu_rd(DTR, 32'h1);
            for (int k = 0; k < 40 && (pin !== 1'b1 || p == 1); k++) wt(1);
            // The low-run length is latched one edge after the pin rises.
            wt(1);
            if (p == 0) chk(last, 32);
            chk1(pin, !p[0]);
            cpu_rd(DTR, 32'h0);
        end
        // Bank flag in increment and decrement mode.
        for (int d = 0; d < 2; d++) begin
            r = $urandom;
            dir <= d[0];
            cpu_wr(BIC, 32'h3);
            cpu_rd(BIC, 32'h2);
            host.cycle_begin(1'b0, 1'b1, {d[0] ? 8'hFF : 8'h00, r[1:0]}, r[2]);
            wt(5);
            chk1(hbuf, 1'b1);
            host.cycle_end();
            wt(6);
            cpu_rd(BIC, 32'h2);
            host.cycle_begin(1'b0, 1'b1, {d[0] ? 8'h00 : 8'hFF, r[1:0]}, r[2]);
            host.cycle_end();
            wt(6);
            cpu_rd(BIC, 32'h3);
            chk1(irq, 1'b1);
            cpu_wr(BIC, 32'h1);
            cpu_rd(BIC, 32'h1);
            chk1(irq, 1'b0);
            cpu_wr(BIC, 32'h2);
            cpu_rd(BIC, 32'h2);
            chk1(irq, 1'b0);
        end
        // A write is not taken while the clock enable is low.
        en <= 1'b0;
        cpu_wr(BIC, 32'h0);
        en <= 1'b1;
        cpu_rd(BIC, 32'h2);
        // Bank steering.
        for (int i = 0; i < 8; i++) begin
            {boot, bmode, bank_select} <= i[2:0];
            wt(3);
            chk1(hbank, !i[2] && i[0]);
            chk1(cbank, !i[2] && (i[1] ^ i[0]));
        end
        // CPU address decode over all regions, with and without boot mode.
        for (int i = 0; i < 64; i++) begin
            r = $urandom;
            case (i[1:0])
                2'd0: r = {i[4:2], 19'h0, r[9:0]};
                2'd1: r = {i[4:2], 4'h0, r[24:10] | 15'h1, r[9:0]};
                2'd2: r = {i[4:2], 1'b1, r[27:0]};
                default: r = 32'hF84E0000 | {22'h0, r[9:0]};
            endcase
            @(posedge clock_in);
            boot        <= i[5];
            cpu_addr_in <= r;
            wt(2);
            chk1(buf_sel, buf_exp(r, i[5]));
            chk1(prohibit, pro_exp(r, i[5]));
            if (buf_exp(r, i[5])) chk({22'h0, boff}, {22'h0, r[9:0]});
            if (i[4:2] != 3'h7 && i[1:0] != 2'd3) chk1(ext_sel, !buf_exp(r, i[5]) && !pro_exp(r, i[5]));
        end
        // The uncached alias region reaches the buffer in boot mode.
        @(posedge clock_in);
        boot        <= 1'b1;
        cpu_addr_in <= 32'hA0000010;
        wt(2);
        chk1(buf_sel, 1'b1);
        final_report();
    end
endmodule : tb
`default_nettype wire
